// File: pkg/idec_map.svh
// What this block does
// - each instruction is one 14-bit word: opcode part plus operand fields.
// - every word falls in exactly one class: byte, bit, or literal/control.
// - byte and bit words carry a 7-bit register address, 0x00 to 0x7F.
// - byte words: destination bit 0 writes W, 1 writes the file register.
// - bit words: 3-bit field picks one bit of the 8-bit register.
// - literal/control words carry an 8-bit or an 11-bit constant.
// - don't-care bits are ignored; decoding is the same for 0 or 1.
// - one instruction cycle is four clock periods; sequencing steps once per cycle.
// - one cycle per instruction; taken skip or PC change adds a NOP cycle.
// - a named file register is read, even if write-only, then modified; it is written only when it is the destination.
`ifndef IDEC_MAP_SVH
`define IDEC_MAP_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define IDEC_WORD_W 14
`define IDEC_PC_W 13
`define IDEC_CLS_HI 13
`define IDEC_CLS_LO 12
`define IDEC_OP_HI 11
`define IDEC_OP_LO 8
`define IDEC_D_BIT 7
`define IDEC_F_HI 6
`define IDEC_F_LO 0
`define IDEC_B_HI 9
`define IDEC_B_LO 7
`define IDEC_BOP_HI 11
`define IDEC_BOP_LO 10
`define IDEC_K8_HI 7
`define IDEC_K11_HI 10
`define IDEC_JMP_BIT 11

// ----------------------------------------
// encodings
// ----------------------------------------
`define IDEC_TOP_BYTE 2'h0
`define IDEC_TOP_BIT 2'h1
`define IDEC_TOP_JMP 2'h2
`define IDEC_TOP_LIT 2'h3
`define IDEC_OP_MISC 4'h0
`define IDEC_OP_DECFSZ 4'hB
`define IDEC_OP_INCFSZ 4'hF
`define IDEC_MISC_RETURN 7'h08
`define IDEC_MISC_RETFIE 7'h09
`define IDEC_MISC_SLEEP 7'h63
`define IDEC_MISC_CLRWDT 7'h64
`define IDEC_MISC_NOP_MASK 7'h1F

// ----------------------------------------
// timing and reset
// ----------------------------------------
`define IDEC_Q_PER_CYCLE 4
`define IDEC_RESET_PC 13'h0000

`endif

// File: pkg/idec_pkg.sv
`include "idec_map.svh"

package idec_pkg;

  typedef enum logic [3:0] {
    CLS_BYTE = 4'b0001,
    CLS_BIT = 4'b0010,
    CLS_LIT = 4'b0100,
    CLS_CTL = 4'b1000
  } class_t;

  typedef enum logic [4:0] {
    CTL_NONE = 5'b00001,
    CTL_RETURN = 5'b00010,
    CTL_RETFIE = 5'b00100,
    CTL_SLEEP = 5'b01000,
    CTL_CLRWDT = 5'b10000
  } ctl_t;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_t;

  typedef struct packed {
    class_t cls;
    logic [3:0] op;
    logic dest;
    logic [6:0] faddr;
    logic [2:0] bsel;
    logic [10:0] k;
    logic k_wide;
    ctl_t ctl;
    logic uses_file;
    logic is_skip;
    logic skip_on_set;
    logic is_goto;
    logic is_call;
    logic is_ret;
    logic wr_w;
    logic wr_f;
  } dec_t;

  typedef struct packed {
    logic rd;
    logic modify;
    logic wr_f;
    logic wr_w;
    logic push;
    logic pop;
    logic flush;
  } strobe_t;

endpackage

// File: core/phase_gen.sv
`timescale 1ns/100ps
module phase_gen (
  input wire logic clk,
  input wire logic rst,
  output idec_pkg::phase_t phase,
  output logic cycle_end
);
  import idec_pkg::*;

  phase_t phase_r;
  phase_t phase_nxt;

  // ----------------------------------------
  // four-phase rotation
  // ----------------------------------------
  always_comb begin
    unique case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
      default: phase_nxt = PH_Q1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;
  assign cycle_end = (phase_r == PH_Q4);

endmodule

// File: core/word_decoder.sv
`timescale 1ns/100ps
`include "idec_map.svh"
module word_decoder (
  input wire logic [`IDEC_WORD_W-1:0] word,
  output idec_pkg::dec_t dec
);
  import idec_pkg::*;

  // ----------------------------------------
  // field split
  // ----------------------------------------
  wire [1:0] top = word[`IDEC_CLS_HI:`IDEC_CLS_LO];
  wire [3:0] op_raw = word[`IDEC_OP_HI:`IDEC_OP_LO];
  wire [1:0] bop = word[`IDEC_BOP_HI:`IDEC_BOP_LO];
  wire dbit = word[`IDEC_D_BIT];
  wire [6:0] faddr = word[`IDEC_F_HI:`IDEC_F_LO];
  wire is_byte = (top == `IDEC_TOP_BYTE);
  wire is_misc = is_byte && (op_raw == `IDEC_OP_MISC) && !dbit;
  wire byte_op = is_byte && !is_misc;
  wire bit_op = (top == `IDEC_TOP_BIT);
  wire lit_op = (top == `IDEC_TOP_LIT);
  wire jmp_op = (top == `IDEC_TOP_JMP);
  wire bit_test = bit_op && bop[1];
  wire byte_skip = byte_op && ((op_raw == `IDEC_OP_DECFSZ) || (op_raw == `IDEC_OP_INCFSZ));
  wire m_ret = is_misc && (faddr == `IDEC_MISC_RETURN);
  wire m_rfie = is_misc && (faddr == `IDEC_MISC_RETFIE);
  wire m_slp = is_misc && (faddr == `IDEC_MISC_SLEEP);
  wire m_wdt = is_misc && (faddr == `IDEC_MISC_CLRWDT);
  wire retlw = lit_op && (op_raw[3:2] == 2'h1);

  // don't-care literal opcode bits forced to zero
  wire [3:0] lit_norm = (op_raw[3:2] != 2'h2) ?
    ((op_raw[3:2] == 2'h3) ? {op_raw[3:1], 1'b0} : {op_raw[3:2], 2'h0}) : op_raw;
  wire [3:0] op_norm = lit_op ? lit_norm : (bit_op ? {2'h0, bop} : op_raw);

  // ----------------------------------------
  // assembled result
  // ----------------------------------------
  always_comb begin
    dec = '0;
    dec.cls = byte_op ? CLS_BYTE : bit_op ? CLS_BIT : lit_op ? CLS_LIT : CLS_CTL;
    dec.op = op_norm;
    dec.dest = byte_op ? dbit : 1'b0;
    dec.faddr = (byte_op || bit_op) ? faddr : 7'h00;
    dec.bsel = bit_op ? word[`IDEC_B_HI:`IDEC_B_LO] : 3'h0;
    dec.k = jmp_op ? word[`IDEC_K11_HI:0] : {3'h0, word[`IDEC_K8_HI:0]};
    dec.k_wide = jmp_op;
    dec.ctl = m_ret ? CTL_RETURN : m_rfie ? CTL_RETFIE :
              m_slp ? CTL_SLEEP : m_wdt ? CTL_CLRWDT : CTL_NONE;
    dec.uses_file = byte_op || bit_op;
    dec.is_skip = bit_test || byte_skip;
    dec.skip_on_set = bit_test && bop[0];
    dec.is_goto = jmp_op && word[`IDEC_JMP_BIT];
    dec.is_call = jmp_op && !word[`IDEC_JMP_BIT];
    dec.is_ret = m_ret || m_rfie || retlw;
    dec.wr_w = (byte_op && !dbit) || lit_op;
    dec.wr_f = (byte_op && dbit) || (bit_op && !bop[1]);
  end

endmodule

// File: core/instruction_decode_timing.sv
`timescale 1ns/100ps
`include "idec_map.svh"
module instruction_decode_timing (
  input wire logic CLOCK,
  input wire logic RST,
  output logic [`IDEC_PC_W-1:0] PM_ADDR,
  input wire logic [`IDEC_WORD_W-1:0] PM_DATA,
  output idec_pkg::dec_t EXEC_DEC,
  output logic EXEC_VALID,
  output idec_pkg::phase_t PHASE,
  output idec_pkg::strobe_t STROBE,
  output logic [`IDEC_PC_W-1:0] PUSH_ADDR,
  input wire logic [`IDEC_PC_W-1:0] STACK_TOP,
  input wire logic [1:0] PAGE_BITS,
  input wire logic SKIP_COND,
  input wire logic PCL_WRITE,
  input wire logic [`IDEC_PC_W-1:0] PCL_VALUE
);
  import idec_pkg::*;

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  phase_t phase;
  logic cycle_end;

  phase_gen u_phase (
    .clk(CLOCK),
    .rst(RST),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // ----------------------------------------
  // fetched word decode
  // ----------------------------------------
  dec_t fetch_dec;

  word_decoder u_dec (
    .word(PM_DATA),
    .dec(fetch_dec)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [`IDEC_PC_W-1:0] pc_r;
  logic [`IDEC_PC_W-1:0] pc_nxt;
  dec_t exec_r;
  logic valid_r;

  // ----------------------------------------
  // flow decision at end of cycle
  // ----------------------------------------
  wire q2 = (phase == PH_Q2);
  wire q3 = (phase == PH_Q3);
  wire q4 = cycle_end;
  wire skip_hit = exec_r.is_skip && SKIP_COND;
  wire jump_k = exec_r.is_goto || exec_r.is_call;
  wire flow = valid_r && (jump_k || exec_r.is_ret || skip_hit || PCL_WRITE);
  wire [`IDEC_PC_W-1:0] jump_pc = {PAGE_BITS, exec_r.k};
  wire [`IDEC_PC_W-1:0] pc_inc = pc_r + `IDEC_PC_W'(1);

  always_comb begin
    pc_nxt = pc_inc;
    if (valid_r) begin
      if (jump_k) begin
        pc_nxt = jump_pc;
      end else if (exec_r.is_ret) begin
        pc_nxt = STACK_TOP;
      end else if (PCL_WRITE) begin
        pc_nxt = PCL_VALUE;
      end
    end
  end

  // ----------------------------------------
  // per-cycle pipeline advance
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pc_r <= `IDEC_RESET_PC;
      exec_r <= '0;
      valid_r <= 1'b0;
    end else if (q4) begin
      pc_r <= pc_nxt;
      exec_r <= fetch_dec;
      valid_r <= !flow;
    end
  end

  // ----------------------------------------
  // read-modify-write strobes
  // ----------------------------------------
  assign STROBE.rd = valid_r && exec_r.uses_file && q2;
  assign STROBE.modify = valid_r && q3;
  assign STROBE.wr_f = valid_r && exec_r.wr_f && q4;
  assign STROBE.wr_w = valid_r && exec_r.wr_w && q4;
  assign STROBE.push = valid_r && exec_r.is_call && q4;
  assign STROBE.pop = valid_r && exec_r.is_ret && q4;
  assign STROBE.flush = flow && q4;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PM_ADDR = pc_r;
  assign PUSH_ADDR = pc_r;
  assign EXEC_DEC = exec_r;
  assign EXEC_VALID = valid_r;
  assign PHASE = phase;

endmodule

// File: tb/idec_props.sv
`timescale 1ns/100ps
`include "idec_map.svh"
module idec_props (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [`IDEC_PC_W-1:0] PM_ADDR,
  input wire logic [`IDEC_WORD_W-1:0] PM_DATA,
  input idec_pkg::dec_t EXEC_DEC,
  input wire logic EXEC_VALID,
  input idec_pkg::phase_t PHASE,
  input idec_pkg::strobe_t STROBE,
  input wire logic [`IDEC_PC_W-1:0] PUSH_ADDR
);
  import idec_pkg::*;
  // ----------------------------------------
  // port checks
  // ----------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_ph;
    PHASE == PH_Q1 |=> PHASE == PH_Q2 ##1 PHASE == PH_Q3 ##1 PHASE == PH_Q4 ##1 PHASE == PH_Q1;
  endproperty
  a_ph: assert property (p_ph) else $error("phase order");
  property p_pc;
    PHASE != PH_Q4 |=> $stable(PM_ADDR);
  endproperty
  a_pc: assert property (p_pc) else $error("pc moved mid cycle");
  property p_rd;
    STROBE.rd |-> PHASE == PH_Q2 && EXEC_VALID && EXEC_DEC.uses_file;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  property p_mod;
    PHASE == PH_Q3 && EXEC_VALID |-> STROBE.modify;
  endproperty
  a_mod: assert property (p_mod) else $error("modify strobe");
  property p_wf;
    STROBE.wr_f && EXEC_DEC.cls == CLS_BYTE |-> EXEC_DEC.dest;
  endproperty
  a_wf: assert property (p_wf) else $error("file write dest");
  property p_ww;
    STROBE.wr_w && EXEC_DEC.cls == CLS_BYTE |-> !EXEC_DEC.dest;
  endproperty
  a_ww: assert property (p_ww) else $error("w write dest");
  property p_fl;
    STROBE.flush |=> !EXEC_VALID;
  endproperty
  a_fl: assert property (p_fl) else $error("no nop after flush");
  property p_nop;
    !EXEC_VALID |-> STROBE == '0;
  endproperty
  a_nop: assert property (p_nop) else $error("strobe in nop");
  property p_push;
    STROBE.push |-> STROBE.flush && PUSH_ADDR == PM_ADDR;
  endproperty
  a_push: assert property (p_push) else $error("push address");
  property p_fa;
    PHASE == PH_Q4 && !STROBE.flush && PM_DATA[13:12] == 2'h0 && PM_DATA[11:8] != 4'h0
      |=> EXEC_DEC.faddr == $past(PM_DATA[6:0]);
  endproperty
  a_fa: assert property (p_fa) else $error("file address");
endmodule
bind instruction_decode_timing idec_props i_props (.CLOCK, .RST, .PM_ADDR, .PM_DATA,
  .EXEC_DEC, .EXEC_VALID, .PHASE, .STROBE, .PUSH_ADDR);

// File: tb/tb.sv
`timescale 1ns/100ps
`include "idec_map.svh"
module tb;
  import idec_pkg::*;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  logic CLOCK = 0;
  logic RST = 1;
  logic [12:0] PM_ADDR, PUSH_ADDR;
  logic [13:0] PM_DATA = 0;
  logic SKIP_COND = 1'b1;
  logic PCL_WRITE = 1'b0;
  logic [12:0] PCL_VALUE = 13'h000A;
  dec_t EXEC_DEC;
  logic EXEC_VALID;
  phase_t PHASE;
  strobe_t STROBE;
  logic [13:0] mem [16] = '{14'h07A5, 14'h087F, 14'h2005, 14'h30CD, 14'h0000, 14'h1783,
    14'h0B20, 14'h0F00, 14'h33AB, 14'h0008, 14'h1F81, 14'h0000, 14'h2804, 14'h0000,
    14'h0000, 14'h0000};
  int err_count = 0;
  int total_checks = 0;
  always #10 CLOCK = ~CLOCK;
  always @(posedge CLOCK) PM_DATA <= mem[PM_ADDR[3:0]];
  instruction_decode_timing i_dut (.CLOCK(CLOCK), .RST(RST), .PM_ADDR(PM_ADDR),
    .PM_DATA(PM_DATA), .EXEC_DEC(EXEC_DEC), .EXEC_VALID(EXEC_VALID), .PHASE(PHASE),
    .STROBE(STROBE), .PUSH_ADDR(PUSH_ADDR), .STACK_TOP(13'h0003), .PAGE_BITS(2'h1),
    .SKIP_COND(SKIP_COND), .PCL_WRITE(PCL_WRITE), .PCL_VALUE(PCL_VALUE));
  task test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task ins(input logic [12:0] pc, input class_t c, input logic [10:0] v,
    input logic [5:0] s, input logic sk, input logic pw);
    int n;
    n = 0;
    do begin
      @(posedge CLOCK);
      #1;
      n++;
    end while (!(PHASE === PH_Q1 && EXEC_VALID === 1'b1) && n < 40);
    if (n >= 40) begin
      err_count++;
      $display("[ERR] %0t no instruction", $time);
      test_done();
    end
    chk(PM_ADDR, pc);
    chk(EXEC_DEC.cls, c);
    if (c == CLS_LIT) chk(EXEC_DEC.k, v);
    if (c == CLS_LIT) chk(EXEC_DEC.op, 4'h0);
    if (c == CLS_BYTE || c == CLS_BIT) chk(EXEC_DEC.faddr, v);
    if (c == CLS_BIT) chk(EXEC_DEC.bsel, 3'h7);
    if (c == CLS_BYTE) chk(EXEC_DEC.dest, s[3]);
    @(posedge CLOCK);
    SKIP_COND <= sk;
    PCL_WRITE <= pw;
    #1;
    chk(STROBE.rd, s[5]);
    @(posedge CLOCK);
    #1;
    chk(STROBE.modify, 1'b1);
    @(posedge CLOCK);
    #1;
    chk({STROBE.push, STROBE.wr_f, STROBE.wr_w, STROBE.flush, STROBE.pop}, s[4:0]);
    if (s[4]) chk(PUSH_ADDR, pc);
    $display("test at %h done", pc);
  endtask
  task test_reset();
    @(posedge CLOCK);
    RST <= 1'b1;
    @(posedge CLOCK);
    #1;
    chk(PM_ADDR, 13'h0000);
    chk(EXEC_VALID, 1'b0);
    chk(PHASE, PH_Q1);
    chk(STROBE, 7'h00);
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    ins(13'h001, CLS_BYTE, 11'h25, 6'b101000, 1'b1, 1'b0);
    $display("test reset done");
  endtask
  initial begin
    repeat (6) @(posedge CLOCK);
    RST <= 0;
    ins(13'h001, CLS_BYTE, 11'h25, 6'b101000, 1'b1, 1'b0);
    ins(13'h002, CLS_BYTE, 11'h7F, 6'b100100, 1'b1, 1'b0);
    ins(13'h003, CLS_CTL, 11'h000, 6'b010010, 1'b1, 1'b0);
    ins(13'h806, CLS_BIT, 11'h03, 6'b101000, 1'b1, 1'b0);
    ins(13'h807, CLS_BYTE, 11'h20, 6'b100110, 1'b1, 1'b0);
    ins(13'h809, CLS_LIT, 11'hAB, 6'b000100, 1'b1, 1'b0);
    ins(13'h80A, CLS_CTL, 11'h000, 6'b000011, 1'b1, 1'b0);
    ins(13'h004, CLS_LIT, 11'hCD, 6'b000100, 1'b1, 1'b0);
    ins(13'h005, CLS_CTL, 11'h000, 6'b000000, 1'b1, 1'b0);
    ins(13'h006, CLS_BIT, 11'h03, 6'b101000, 1'b1, 1'b0);
    ins(13'h007, CLS_BYTE, 11'h20, 6'b100100, 1'b0, 1'b0);
    ins(13'h008, CLS_BYTE, 11'h00, 6'b100110, 1'b0, 1'b1);
    ins(13'h00B, CLS_BIT, 11'h01, 6'b100010, 1'b1, 1'b0);
    ins(13'h00D, CLS_CTL, 11'h000, 6'b000010, 1'b1, 1'b0);
    ins(13'h805, CLS_CTL, 11'h000, 6'b000000, 1'b1, 1'b0);
    test_reset();
    test_done();
  end
endmodule
